//--- hdl/acfg_port.v
// Three-wire configuration port with its register file and the output
// test-pattern generator. Serial pins are asynchronous and oversampled by
// core_clk_i; sample_en_i marks a running converter sample clock.
`timescale 1ns/100ps
`include "acfg_map.vh"
module acfg_port #(
    parameter [7:0] CHIP_ID = 8'h5a
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire sclk_i,
    input wire port_select_n_i,
    input wire sdio_i,
    input wire power_off_pin_i,
    input wire sample_en_i,
    input wire [15:0] conv_data_i,
    output reg sdio_o,
    output reg sdio_oe_o,
    output reg data_valid_o,
    output reg [15:0] data_o,
    output reg format_en_o,
    output reg test_active_o,
    output reg power_down_o,
    output reg duty_cycle_stabilizer_o,
    output reg lane_one_o,
    output reg spi_mode_o
);
// ****************************************
// Functions
// ****************************************
// Sixteen steps of x^9+x^5+1; returns {state, word}
function [24:0] pns_adv;
    input [8:0] s;
    integer i;
    reg [8:0] t;
    reg [15:0] w;
    reg b;
    begin
        t = s;
        w = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            b = t[8] ^ t[4];
            t = {t[7:0], b};
            w = {w[14:0], b};
        end
        pns_adv = {t, w};
    end
endfunction
// Sixteen steps of x^23+x^18+1, stream inverted; returns {state, word}
function [38:0] pnl_adv;
    input [22:0] s;
    integer i;
    reg [22:0] t;
    reg [15:0] w;
    reg b;
    begin
        t = s;
        w = 16'h0000;
        for (i = 0; i < 16; i = i + 1) begin
            b = t[22] ^ t[17];
            t = {t[21:0], b};
            w = {w[14:0], ~b};
        end
        pnl_adv = {t, w};
    end
endfunction
function [7:0] bit_rev;
    input [7:0] v;
    integer i;
    begin
        for (i = 0; i < 8; i = i + 1)
            bit_rev[i] = v[7 - i];
    end
endfunction
// ****************************************
// Pin synchronisers
// ****************************************
// Bit 0 is the first flop; only bit 1 and the edge flop read further
reg [2:0] sclk_s;
reg [2:0] cs_s;
reg [1:0] sd_s;
reg [1:0] pd_s;
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        sclk_s <= 3'h0;
        cs_s <= 3'h7;
        sd_s <= 2'h0;
        pd_s <= 2'h0;
    end else begin
        sclk_s <= {sclk_s[1:0], sclk_i};
        cs_s <= {cs_s[1:0], port_select_n_i};
        sd_s <= {sd_s[0], sdio_i};
        pd_s <= {pd_s[0], power_off_pin_i};
    end
end
wire sck_rise = sclk_s[1] & ~sclk_s[2];
wire sck_fall = ~sclk_s[1] & sclk_s[2];
wire cs_low = ~cs_s[1];
wire cs_fall = ~cs_s[1] & cs_s[2];
wire cs_rise = cs_s[1] & ~cs_s[2];
// ****************************************
// Power-up straps
// ****************************************
reg [1:0] strap_cnt;
reg strap_done;
reg lane_strap;
reg pattern_strap;
reg pd_strap;
reg spi_mode;
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        strap_cnt <= 2'h0;
        strap_done <= 1'b0;
        lane_strap <= 1'b1;
        pattern_strap <= 1'b0;
        pd_strap <= 1'b0;
        spi_mode <= 1'b0;
    end else begin
        if (!strap_done) begin
            strap_cnt <= strap_cnt + 2'h1;
            // Wait until the synchronisers hold real pin levels
            if (strap_cnt == `ACFG_STRAP_WAIT) begin
                strap_done <= 1'b1;
                lane_strap <= sd_s[1];
                pattern_strap <= sclk_s[1] & cs_s[1];
                pd_strap <= pd_s[1];
            end
        end else if (cs_low) begin
            spi_mode <= 1'b1;
        end
    end
end
// ****************************************
// Register file
// ****************************************
reg lsb_first;
reg pwr_pd;
reg dcs_en;
reg lane_one_r;
reg [7:0] test_reg;
reg [7:0] usr [0:3];
reg wr_en;
reg [12:0] wr_addr;
reg [7:0] wr_data;
wire [1:0] usr_idx = wr_addr[1:0] - 2'h1;
integer k;
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        lsb_first <= 1'b0;
        pwr_pd <= 1'b0;
        dcs_en <= `ACFG_DCS_RST;
        lane_one_r <= 1'b0;
        test_reg <= `ACFG_TEST_RST;
        for (k = 0; k < 4; k = k + 1)
            usr[k] <= `ACFG_USR_RST;
    end else if (wr_en) begin
        case (wr_addr)
            `ACFG_A_CFG: begin
                // Soft reset is never stored, so it reads back clear
                if (wr_data[`ACFG_CFG_SRST_HI] | wr_data[`ACFG_CFG_SRST_LO]) begin
                    lsb_first <= 1'b0;
                    pwr_pd <= 1'b0;
                    dcs_en <= `ACFG_DCS_RST;
                    lane_one_r <= 1'b0;
                    test_reg <= `ACFG_TEST_RST;
                    for (k = 0; k < 4; k = k + 1)
                        usr[k] <= `ACFG_USR_RST;
                end else begin
                    lsb_first <= wr_data[`ACFG_CFG_LSB_HI] | wr_data[`ACFG_CFG_LSB_LO];
                end
            end
            `ACFG_A_PWR: pwr_pd <= wr_data[0];
            `ACFG_A_DCS: dcs_en <= wr_data[0];
            `ACFG_A_LANE: lane_one_r <= wr_data[0];
            `ACFG_A_TEST: test_reg <= wr_data;
            default: begin
                if (wr_addr >= `ACFG_A_USR0 && wr_addr <= `ACFG_A_USR3)
                    usr[usr_idx] <= wr_data;
            end
        endcase
    end
end
// ****************************************
// Serial frame engine
// ****************************************
reg frame_on;
reg data_ph;
reg done;
reg [3:0] cnt;
reg [15:0] instr;
reg rw;
reg [1:0] wlen;
reg [1:0] nbytes;
reg [12:0] addr;
wire [15:0] instr_full = {instr[14:0], sd_s[1]};
wire [7:0] byte_in = {instr[6:0], sd_s[1]};
reg [7:0] rd_now;
// Decoded inline so a register change alone refreshes the read byte
always @* begin
    case (addr)
        `ACFG_A_CFG: rd_now = `ACFG_CFG_FIXED | {1'b0, lsb_first, 4'h0, lsb_first, 1'b0};
        `ACFG_A_ID: rd_now = CHIP_ID;  // Arbitrary identification value
        `ACFG_A_PWR: rd_now = {7'h00, pwr_pd};
        `ACFG_A_DCS: rd_now = {7'h00, dcs_en};
        `ACFG_A_LANE: rd_now = {7'h00, lane_one_r};
        `ACFG_A_TEST: rd_now = test_reg;
        13'h0019: rd_now = usr[0];
        13'h001a: rd_now = usr[1];
        13'h001b: rd_now = usr[2];
        13'h001c: rd_now = usr[3];
        default: rd_now = 8'h00;
    endcase
end
wire [2:0] rd_pos = lsb_first ? cnt[2:0] : 3'h7 - cnt[2:0];
wire rd_drive = frame_on & data_ph & rw & ~done;
wire last_byte = (wlen != 2'h3) && (nbytes == wlen);
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        frame_on <= 1'b0;
        data_ph <= 1'b0;
        done <= 1'b0;
        cnt <= 4'h0;
        instr <= 16'h0000;
        rw <= 1'b0;
        wlen <= 2'h0;
        nbytes <= 2'h0;
        addr <= 13'h0000;
        wr_en <= 1'b0;
        wr_addr <= 13'h0000;
        wr_data <= 8'h00;
        sdio_o <= 1'b0;
        sdio_oe_o <= 1'b0;
    end else begin
        wr_en <= 1'b0;
        if (cs_rise) begin
            sdio_oe_o <= 1'b0;
            // Counted frames stall at a byte boundary; a stream ends at select rise
            if (done || cnt[2:0] != 3'h0 || !data_ph || wlen == 2'h3)
                frame_on <= 1'b0;
        end else if (cs_fall && spi_mode_o) begin
            if (!frame_on) begin
                frame_on <= 1'b1;
                data_ph <= 1'b0;
                done <= 1'b0;
                cnt <= 4'h0;
            end else if (rd_drive) begin
                sdio_oe_o <= 1'b1;
                sdio_o <= rd_now[rd_pos];
            end
        end else if (cs_low && frame_on) begin
            if (sck_rise && !data_ph) begin
                instr <= instr_full;
                cnt <= cnt + 4'h1;
                if (cnt == 4'hf) begin
                    data_ph <= 1'b1;
                    rw <= instr_full[15];
                    wlen <= instr_full[14:13];
                    addr <= instr_full[12:0];
                    nbytes <= 2'h0;
                end
            end else if (sck_rise && !done) begin
                instr <= {instr[14:0], sd_s[1]};
                cnt <= {1'b0, cnt[2:0] + 3'h1};
                if (cnt[2:0] == 3'h7) begin
                    if (!rw) begin
                        wr_en <= 1'b1;
                        wr_addr <= addr;
                        wr_data <= lsb_first ? bit_rev(byte_in) : byte_in;
                    end
                    addr <= lsb_first ? addr + 13'h0001 : addr - 13'h0001;
                    nbytes <= nbytes + 2'h1;
                    if (last_byte)
                        done <= 1'b1;
                end
            end else if (sck_fall) begin
                sdio_oe_o <= rd_drive;
                if (rd_drive)
                    sdio_o <= rd_now[rd_pos];
            end
        end
    end
end
// ****************************************
// Test pattern generator
// ****************************************
reg [8:0] pns;
reg [22:0] pnl;
reg tog;
wire [24:0] pns_nx = pns_adv(pns);
wire [38:0] pnl_nx = pnl_adv(pnl);
wire [3:0] code = spi_mode ? test_reg[3:0] :
    (pattern_strap ? `ACFG_P_ONEBIT : `ACFG_P_OFF);
reg [15:0] pat;
reg pat_fmt;
always @* begin
    pat = conv_data_i;
    pat_fmt = 1'b1;
    case (code)
        `ACFG_P_MID: pat = `ACFG_V_MID;
        `ACFG_P_PFS: pat = `ACFG_V_PFS;
        `ACFG_P_NFS: pat = `ACFG_V_NFS;
        `ACFG_P_PNL: pat = pnl_nx[15:0];
        `ACFG_P_PNS: pat = pns_nx[15:0];
        `ACFG_P_CHECK: begin
            pat = tog ? `ACFG_V_CHECK2 : `ACFG_V_CHECK1;
            pat_fmt = 1'b0;
        end
        `ACFG_P_WTOG: begin
            pat = tog ? `ACFG_V_WTOG2 : `ACFG_V_WTOG1;
            pat_fmt = 1'b0;
        end
        `ACFG_P_USER: begin
            pat = tog ? {usr[3], usr[2]} : {usr[1], usr[0]};
            pat_fmt = 1'b0;
        end
        `ACFG_P_BTOG: begin
            pat = `ACFG_V_BTOG;
            pat_fmt = 1'b0;
        end
        `ACFG_P_SYNC: begin
            pat = `ACFG_V_SYNC;
            pat_fmt = 1'b0;
        end
        `ACFG_P_ONEBIT: begin
            pat = `ACFG_V_ONEBIT;
            pat_fmt = 1'b0;
        end
        `ACFG_P_MIXED: begin
            pat = `ACFG_V_MIXED;
            pat_fmt = 1'b0;
        end
        default: pat = conv_data_i;
    endcase
end
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        pns <= `ACFG_PNS_SEED;
        pnl <= `ACFG_PNL_SEED;
        tog <= 1'b0;
        data_o <= 16'h0000;
        data_valid_o <= 1'b0;
        format_en_o <= 1'b1;
        test_active_o <= 1'b0;
    end else begin
        data_valid_o <= sample_en_i;
        test_active_o <= code != `ACFG_P_OFF;
        if (test_reg[`ACFG_T_SHORT_RST])
            pns <= `ACFG_PNS_SEED;
        else if (sample_en_i && code == `ACFG_P_PNS)
            pns <= pns_nx[24:16];
        if (test_reg[`ACFG_T_LONG_RST])
            pnl <= `ACFG_PNL_SEED;
        else if (sample_en_i && code == `ACFG_P_PNL)
            pnl <= pnl_nx[38:16];
        // Held while the sample clock is stopped
        if (sample_en_i) begin
            tog <= ~tog;
            data_o <= pat;
            format_en_o <= pat_fmt;
        end
    end
end
// ****************************************
// Static controls
// ****************************************
always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
        power_down_o <= 1'b0;
        duty_cycle_stabilizer_o <= 1'b1;
        lane_one_o <= 1'b0;
        spi_mode_o <= 1'b0;
    end else begin
        spi_mode_o <= spi_mode;
        power_down_o <= spi_mode ? (pd_s[1] | pwr_pd) : pd_strap;
        duty_cycle_stabilizer_o <= spi_mode ? dcs_en : 1'b1;
        lane_one_o <= spi_mode ? lane_one_r : ~lane_strap;
    end
end
endmodule

//--- hdl/acfg_map.vh
// Constants of the converter configuration port: offsets, fields, defaults,
// pattern codes and values. Definitions only; included by acfg_port.v.
`ifndef ACFG_MAP_VH
`define ACFG_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define ACFG_A_CFG 13'h0000
`define ACFG_A_ID 13'h0001
`define ACFG_A_PWR 13'h0008
`define ACFG_A_DCS 13'h0009
`define ACFG_A_TEST 13'h000d
`define ACFG_A_USR0 13'h0019
`define ACFG_A_USR3 13'h001c
`define ACFG_A_LANE 13'h0021
// ****************************************
// Fields and reset values
// ****************************************
`define ACFG_CFG_FIXED 8'h18
`define ACFG_CFG_LSB_HI 6
`define ACFG_CFG_LSB_LO 1
`define ACFG_CFG_SRST_HI 5
`define ACFG_CFG_SRST_LO 2
`define ACFG_T_LONG_RST 4
`define ACFG_T_SHORT_RST 5
`define ACFG_TEST_RST 8'h00
`define ACFG_USR_RST 8'h00
`define ACFG_DCS_RST 1'b1
`define ACFG_STRAP_WAIT 2'h3
// ****************************************
// Pattern codes and values
// ****************************************
`define ACFG_P_OFF 4'h0
`define ACFG_P_MID 4'h1
`define ACFG_P_PFS 4'h2
`define ACFG_P_NFS 4'h3
`define ACFG_P_CHECK 4'h4
`define ACFG_P_PNL 4'h5
`define ACFG_P_PNS 4'h6
`define ACFG_P_WTOG 4'h7
`define ACFG_P_USER 4'h8
`define ACFG_P_BTOG 4'h9
`define ACFG_P_SYNC 4'ha
`define ACFG_P_ONEBIT 4'hb
`define ACFG_P_MIXED 4'hc
`define ACFG_V_MID 16'h8000
`define ACFG_V_PFS 16'hffff
`define ACFG_V_NFS 16'h0000
`define ACFG_V_CHECK1 16'haaaa
`define ACFG_V_CHECK2 16'h5554
`define ACFG_V_WTOG1 16'hfffc
`define ACFG_V_WTOG2 16'h0000
`define ACFG_V_BTOG 16'haaa8
`define ACFG_V_SYNC 16'h01fc
`define ACFG_V_ONEBIT 16'h8000
`define ACFG_V_MIXED 16'ha19c
`define ACFG_PNS_SEED 9'h1ff
`define ACFG_PNL_SEED 23'h7fffff
`endif

//--- tb/acfg_host.sv
// Serial host model that drives the three-wire configuration port.
// Assumes the bench calls its tasks and feeds back the device data pin.
`timescale 1ns/100ps
module acfg_host (
    output logic sclk_o,
    output logic port_select_n_o,
    output wire sdio_line_o,
    input wire sdio_dev_i,
    input wire sdio_dev_oe_i
);
    localparam int HALF = 80;
    logic drv = 1'b1;
    logic bit_val = 1'b1;
    logic last = 1'b1;
    logic lsb_first = 1'b0;
    initial sclk_o = 1'b0;
    initial port_select_n_o = 1'b1;
    // No pull on the line: released, it shows the inverse of its last level
    assign sdio_line_o = sdio_dev_oe_i ? sdio_dev_i : (drv ? bit_val : ~last);
    always @(sdio_line_o) if (sdio_dev_oe_i || drv) last = sdio_line_o;
    task automatic shift(input logic b);
        bit_val = b;
        drv = 1'b1;
        #HALF sclk_o = 1'b1;
        #HALF sclk_o = 1'b0;
    endtask
    // First select fall only arms the port
    task automatic wake();
        #3 port_select_n_o = 1'b0;
        #200 port_select_n_o = 1'b1;
        #(2*HALF);
    endtask
    task automatic frame(input logic rd, input logic [1:0] wl, input logic [12:0] addr,
                         input int n, input logic [31:0] wd, input int stall_at,
                         output logic [31:0] rdat);
        logic [15:0] ins;
        int j;
        ins = {rd, wl, addr};
        rdat = 32'h0;
        port_select_n_o = 1'b0;
        #HALF;
        for (int i = 15; i >= 0; i--) shift(ins[i]);
        for (int k = 0; k < n; k++) begin
            if (k == stall_at) begin
                port_select_n_o = 1'b1;
                #(4*HALF) port_select_n_o = 1'b0;
                #HALF;
            end
            for (int i = 0; i < 8; i++) begin
                j = lsb_first ? i : 7 - i;
                if (rd) begin
                    drv = 1'b0;
                    #HALF sclk_o = 1'b1;
                    rdat[24-8*k+j] = sdio_line_o;
                    #HALF sclk_o = 1'b0;
                end else begin
                    shift(wd[24-8*k+j]);
                end
            end
        end
        drv = 1'b0;
        #HALF port_select_n_o = 1'b1;
        #(2*HALF);
    endtask
endmodule

//--- tb/acfg_checker.sv
// Assertions on the configuration port outputs.
// Assumes a bind to acfg_port; sees its ports only.
`timescale 1ns/100ps
module acfg_checker (
    input wire core_clk_i,
    input wire rst_i,
    input wire port_select_n_i,
    input wire power_off_pin_i,
    input wire sample_en_i,
    input wire [15:0] conv_data_i,
    input wire sdio_oe_o,
    input wire data_valid_o,
    input wire [15:0] data_o,
    input wire test_active_o,
    input wire power_down_o,
    input wire duty_cycle_stabilizer_o,
    input wire lane_one_o,
    input wire spi_mode_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    logic [3:0] up_cnt;
    // Straps land a few edges after reset, so hold checks start later
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            up_cnt <= 4'h0;
        end else if (up_cnt != 4'hf) begin
            up_cnt <= up_cnt + 4'h1;
        end
    end
    a_valid_follows: assert property (sample_en_i |=> data_valid_o)
        else $error("valid missing after sample");
    a_data_hold: assert property (!sample_en_i |=> $stable(data_o))
        else $error("output word moved without sample");
    a_conv_pass: assert property (sample_en_i && !test_active_o ##1 !test_active_o
        |-> data_o == $past(conv_data_i)) else $error("converter word not passed");
    a_oe_deselect: assert property (port_select_n_i [*8] |-> !sdio_oe_o)
        else $error("data pin driven while deselected");
    a_oe_needs_spi: assert property (!spi_mode_o |-> !sdio_oe_o)
        else $error("data pin driven outside serial mode");
    a_dcs_default: assert property (!spi_mode_o |-> duty_cycle_stabilizer_o)
        else $error("stabilizer off outside serial mode");
    a_pin_power: assert property (spi_mode_o && power_off_pin_i [*5] |-> power_down_o)
        else $error("power pin ignored in serial mode");
    a_strap_hold: assert property (up_cnt == 4'hf && !spi_mode_o
        |=> spi_mode_o || ($stable(power_down_o) && $stable(lane_one_o)))
        else $error("strap value moved");
    c_pattern: cover property (test_active_o && data_valid_o);
    c_read: cover property (sdio_oe_o);
    c_pin: cover property (spi_mode_o && power_down_o);
endmodule

//--- tb/tb.sv
// Top testbench of the configuration port and its pattern generator.
// Assumes acfg_port, acfg_host and acfg_checker are compiled before it.
`timescale 1ns/100ps
module tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic power_off_pin_i = 1'b0;
    logic sample_en_i = 1'b0;
    logic [15:0] conv_data_i = 16'h1234;
    wire sclk_i, port_select_n_i, sdio_i, sdio_o, sdio_oe_o, data_valid_o, format_en_o;
    wire test_active_o, power_down_o, duty_cycle_stabilizer_o, lane_one_o, spi_mode_o;
    wire [15:0] data_o;
    int mismatches = 0;
    int compares = 0;
    logic [3:0] codes [9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc};
    logic [15:0] w1 [9] = '{16'h8000, 16'hffff, 16'h0000, 16'haaaa, 16'hfffc, 16'haaa8,
                            16'h01fc, 16'h8000, 16'ha19c};
    logic [15:0] w2 [9] = '{16'h8000, 16'hffff, 16'h0000, 16'h5554, 16'h0000, 16'haaa8,
                            16'h01fc, 16'h8000, 16'ha19c};
    always #5 core_clk_i = ~core_clk_i;
    // Chip identity value is arbitrary
    acfg_port #(.CHIP_ID(8'h3c)) u_acfg_port (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .sclk_i(sclk_i), .port_select_n_i(port_select_n_i), .sdio_i(sdio_i),
        .power_off_pin_i(power_off_pin_i), .sample_en_i(sample_en_i),
        .conv_data_i(conv_data_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o),
        .data_valid_o(data_valid_o), .data_o(data_o), .format_en_o(format_en_o),
        .test_active_o(test_active_o), .power_down_o(power_down_o),
        .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o), .lane_one_o(lane_one_o),
        .spi_mode_o(spi_mode_o));
    acfg_host u_acfg_host (.sclk_o(sclk_i), .port_select_n_o(port_select_n_i),
        .sdio_line_o(sdio_i), .sdio_dev_i(sdio_o), .sdio_dev_oe_i(sdio_oe_o));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [31:0] r;
        u_acfg_host.frame(1'b0, 2'b00, a, 1, {d, 24'h0}, 9, r);
    endtask
    task automatic rd_chk(input string what, input logic [12:0] a, input logic [7:0] e);
        logic [31:0] r;
        u_acfg_host.frame(1'b1, 2'b00, a, 1, 32'h0, 9, r);
        check(what, {8'h0, e}, {8'h0, r[31:24]});
    endtask
    // Samples run only with the port idle, to keep serial noise off the converter
    task automatic pulse(output logic [15:0] w);
        @(negedge core_clk_i);
        sample_en_i = 1'b1;
        @(negedge core_clk_i);
        sample_en_i = 1'b0;
        w = data_o;
        check("valid", 16'h1, {15'h0, data_valid_o});
    endtask
    task automatic pair_chk(input string what, input logic [15:0] a, input logic [15:0] b);
        logic [15:0] x, y;
        pulse(x);
        pulse(y);
        check(what, 16'h1, {15'h0, (x === a && y === b) || (x === b && y === a)});
    endtask
    task automatic t_strap();
        check("lane strap", 16'h0, {15'h0, lane_one_o});
        check("dcs strap", 16'h1, {15'h0, duty_cycle_stabilizer_o});
        repeat (16) @(negedge core_clk_i);
        power_off_pin_i = 1'b1;
        repeat (10) @(negedge core_clk_i);
        check("power strap", 16'h0, {15'h0, power_down_o});
        power_off_pin_i = 1'b0;
        u_acfg_host.wake();
        check("serial mode", 16'h1, {15'h0, spi_mode_o});
    endtask
    task automatic t_regs();
        rd_chk("cfg", 13'h0000, 8'h18);
        wr(13'h0001, 8'h00);
        rd_chk("id", 13'h0001, 8'h3c);
        rd_chk("unmapped", 13'h0013, 8'h00);
        wr(13'h0009, 8'h00);
        check("dcs off", 16'h0, {15'h0, duty_cycle_stabilizer_o});
        wr(13'h0009, 8'h01);
        power_off_pin_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        check("power pin", 16'h1, {15'h0, power_down_o});
        power_off_pin_i = 1'b0;
        wr(13'h0008, 8'h01);
        check("power reg", 16'h1, {15'h0, power_down_o});
        wr(13'h0008, 8'h00);
    endtask
    task automatic t_user();
        logic [31:0] r;
        u_acfg_host.frame(1'b0, 2'b11, 13'h001c, 2, 32'hc1c20000, 9, r);
        u_acfg_host.frame(1'b0, 2'b01, 13'h001a, 2, 32'hc3c40000, 1, r);
        u_acfg_host.frame(1'b1, 2'b01, 13'h001a, 2, 32'h0, 9, r);
        check("two bytes", 16'hc3c4, r[31:16]);
        u_acfg_host.frame(1'b1, 2'b10, 13'h001c, 3, 32'h0, 1, r);
        check("three bytes", 16'hc1c2, r[31:16]);
        check("third byte", 16'h00c3, {8'h0, r[15:8]});
        wr(13'h000d, 8'h08);
        pair_chk("user words", 16'hc3c4, 16'hc1c2);
        check("user fmt", 16'h0, {15'h0, format_en_o});
    endtask
    task automatic t_patterns();
        logic [15:0] x;
        for (int i = 0; i < 9; i++) begin
            wr(13'h000d, {4'h0, codes[i]});
            pair_chk("pattern", w1[i], w2[i]);
            check("fmt", {15'h0, i < 3}, {15'h0, format_en_o});
            check("active", 16'h1, {15'h0, test_active_o});
        end
        wr(13'h000d, 8'h00);
        pulse(x);
        check("off", conv_data_i, x);
    endtask
    task automatic t_pn();
        logic [15:0] x, y;
        for (int i = 0; i < 2; i++) begin
            wr(13'h000d, i ? 8'h26 : 8'h15);
            pulse(x);
            pulse(y);
            check("pn held", 16'h1, {15'h0, x === y});
            wr(13'h000d, i ? 8'h06 : 8'h05);
            pulse(x);
            pulse(y);
            check("pn runs", 16'h1, {15'h0, x !== y});
            check("pn fmt", 16'h1, {15'h0, format_en_o});
        end
    endtask
    task automatic t_lsb();
        logic [15:0] x;
        wr(13'h0000, 8'h42);
        u_acfg_host.lsb_first = 1'b1;
        wr(13'h000d, 8'h03);
        rd_chk("lsb read", 13'h000d, 8'h03);
        pulse(x);
        check("lsb code", 16'h0000, x);
        wr(13'h0000, 8'h24);
        u_acfg_host.lsb_first = 1'b0;
        rd_chk("srst cfg", 13'h0000, 8'h18);
        rd_chk("srst test", 13'h000d, 8'h00);
        rd_chk("srst user", 13'h001c, 8'h00);
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        t_strap();
        t_regs();
        t_user();
        t_patterns();
        t_pn();
        t_lsb();
        end_sim();
    end
    initial begin
        #1000000;
        mismatches++;
        end_sim();
    end
endmodule
bind acfg_port acfg_checker u_acfg_checker (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .port_select_n_i(port_select_n_i), .power_off_pin_i(power_off_pin_i),
    .sample_en_i(sample_en_i), .conv_data_i(conv_data_i), .sdio_oe_o(sdio_oe_o),
    .data_valid_o(data_valid_o), .data_o(data_o), .test_active_o(test_active_o),
    .power_down_o(power_down_o), .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o),
    .lane_one_o(lane_one_o), .spi_mode_o(spi_mode_o));
